//--- rtl/status_irq_pkg.sv
// Shared constants for the status and interrupt flag block
package status_irq_pkg;

    // Register offsets (byte addresses on the plain register port)
    localparam logic [7:0]  MASTER_STATUS_OFS     = 8'h20;
    localparam logic [7:0]  MASTER_IRQ_MASK_OFS   = 8'h24;
    localparam logic [7:0]  LOOP_STATUS_OFS       = 8'h30;
    localparam logic [7:0]  LOOP_IRQ_MASK_OFS     = 8'h34;

    // Register geometry and reset values
    localparam int          REG_WIDTH             = 16;
    localparam int          PORT_COUNT            = 16;
    localparam logic [15:0] REG_RESET             = 16'h0000;

    // Master status field positions
    localparam int          SYS_ERR_BIT           = 3;
    localparam int          PARITY_ERR_BIT        = 4;
    localparam int          LOCAL_TIMEOUT_BIT     = 14;
    localparam int          LOCAL_IRQ_BIT         = 15;

    // Mask bits that exist in the master mask register (0..4, 14, 15)
    localparam logic [15:0] MASTER_MASK_IMPL      = 16'hC01F;

    // Local ready must be seen within this many local clock periods
    localparam int          LOCAL_READY_LIMIT     = 9;
    localparam int          LOCAL_BUS_CLOCK_CNT_W            = 4;

    typedef enum logic {
        WD_IDLE,
        WD_WAIT
    } watchdog_state_e;

endpackage

//--- rtl/flag_bank_if.sv
// Interface joining the top module to a bank of sticky flags
`timescale 1ns/1ps
interface flag_bank_if #(
    parameter int WIDTH = 16
);
    logic [WIDTH-1:0] setPulse;
    logic [WIDTH-1:0] clearReq;
    logic [WIDTH-1:0] flags;

    modport owner (input setPulse, input clearReq, output flags);
    modport user  (output setPulse, output clearReq, input flags);
endinterface

//--- rtl/sticky_flag_bank.sv
// Bank of sticky event flags, set by pulses and cleared on request
`timescale 1ns/1ps
module sticky_flag_bank
    import status_irq_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic      clk,
    input  wire logic      rst_n,
    // Flag traffic
    flag_bank_if.owner     bank
);

    logic [WIDTH-1:0] flags_q;
    logic [WIDTH-1:0] flags_d;

    // One flag per bit; a set arriving with a clear survives
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : gFlag
            assign flags_d[i] = bank.setPulse[i] |
                                (flags_q[i] & ~bank.clearReq[i]);
        end
    endgenerate

    // Flags start cleared
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags_q <= REG_RESET[WIDTH-1:0];
        end else begin
            flags_q <= flags_d;
        end
    end

    assign bank.flags = flags_q;

endmodule

//--- rtl/local_ready_watchdog.sv
// Counts local clock periods while an access waits for local ready
`timescale 1ns/1ps
module local_ready_watchdog
    import status_irq_pkg::*;
(
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   rst_n,
    // Local access monitoring
    input  wire logic   enable,
    input  wire logic   accessStart,
    input  wire logic   localBusClock,
    input  wire logic   localReady_n,
    // Result
    output logic        timeoutPulse
);

    watchdog_state_e       state_q;
    watchdog_state_e       state_d;
    logic [LOCAL_BUS_CLOCK_CNT_W-1:0] periods_q;
    logic [LOCAL_BUS_CLOCK_CNT_W-1:0] periods_d;
    logic                  lclkPrev_q;
    logic                  timeout_q;
    logic                  timeout_d;
    wire                   lclkRise = localBusClock & ~lclkPrev_q;
    wire                   limitHit = (periods_q ==
                                       LOCAL_BUS_CLOCK_CNT_W'(LOCAL_READY_LIMIT - 1));

    // Wait state counts local clock edges until ready or the limit
    always_comb begin
        state_d   = state_q;
        periods_d = periods_q;
        timeout_d = 1'b0;
        case (state_q)
            WD_IDLE: begin
                if (enable && accessStart) begin
                    state_d   = WD_WAIT;
                    periods_d = '0;
                end
            end
            WD_WAIT: begin
                if (!enable || !localReady_n) begin
                    state_d = WD_IDLE;
                end else if (lclkRise) begin
                    if (limitHit) begin
                        state_d   = WD_IDLE;
                        timeout_d = 1'b1;
                    end else begin
                        periods_d = periods_q + 1'b1;
                    end
                end
            end
            default: begin
                state_d = WD_IDLE;
            end
        endcase
    end

    // Short state registers; the pulse is one cycle wide
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q    <= WD_IDLE;
            periods_q  <= '0;
            lclkPrev_q <= 1'b0;
            timeout_q  <= 1'b0;
        end else begin
            state_q    <= state_d;
            periods_q  <= periods_d;
            lclkPrev_q <= localBusClock;
            timeout_q  <= timeout_d;
        end
    end

    assign timeoutPulse = timeout_q;

endmodule

//--- rtl/status_interrupt_flags.sv
// Master and loopback status flags, their masks and interrupt outputs
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
// Notes on behaviour
// - Bus error sets system-error flag, bit 3
// - Status read clears system-error flag until recurrence
// - Both error flags mirrored to config status
// - Parity errors set parity flag, bit 4
// - Missing ready in nine periods sets bit 14
// - Local interrupt sets bit 15; host output only
// - Unmasked flag drives host, local in config
// - Master mask at 0x24, bits 0-4,14,15
// - Mask zero blocks, one passes interrupt
// - Status and masks read zero after reset
// - Loopback status at 0x30, one bit per port
// - Detector timeout or pattern sets port flag
// - Timeout keeps port flag set while it stays high
// - Loopback mask at 0x34, one bit per port
// - Reading a status register clears its flags
// - Masking never stops flags from recording
// - Master status register sits at 0x20
module status_interrupt_flags
    import status_irq_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // Register port
    input  wire logic [7:0]             regAddr,
    input  wire logic [REG_WIDTH-1:0]   regWrData,
    input  wire logic                   regWr,
    input  wire logic                   regRd,
    output logic      [REG_WIDTH-1:0]   regRdData,
    // Host bus error events, one-cycle pulses
    input  wire logic                   hostSysErrEvt,
    input  wire logic                   hostParityErrEvt,
    // Mirror into the host configuration status register
    output logic                        cfgSysErrFlag,
    output logic                        cfgParityErrFlag,
    // Local bus mode and access monitoring
    input  wire logic                   localCfgMode,
    input  wire logic                   localAccessStart,
    input  wire logic                   localBusClock,
    input  wire logic                   localReady_n,
    // Two-way local interrupt pin
    input  wire logic                   localIrqIn_n,
    output logic                        localIrqOut_n,
    output logic                        localIrqOe,
    // Loopback detectors, one per port
    input  wire logic [PORT_COUNT-1:0]  loopSearchTimeout,
    input  wire logic [PORT_COUNT-1:0]  loopPatternEvt,
    // Host interrupt
    output logic                        hostIrqOut_n
);

    // Register decode helper, shared by read and write paths
    function automatic logic hits(input logic [7:0] addr,
                                  input logic [7:0] ofs);
        hits = (addr == ofs);
    endfunction

    flag_bank_if #(.WIDTH(REG_WIDTH))  masterBank ();
    flag_bank_if #(.WIDTH(PORT_COUNT)) loopBank ();

    logic [REG_WIDTH-1:0]  masterMask_q;
    logic [PORT_COUNT-1:0] loopMask_q;
    logic [REG_WIDTH-1:0]  rdData_q;
    logic [REG_WIDTH-1:0]  rdData_d;
    logic                  localIrqPrev_q;
    logic                  hostIrq_n_q;
    logic                  localIrqOut_n_q;
    logic                  localIrqOe_q;
    logic                  cfgSysErr_q;
    logic                  cfgParityErr_q;
    logic                  localTimeoutEvt;

    // Address decode
    wire selMasterStatus = hits(regAddr, MASTER_STATUS_OFS);
    wire selMasterMask   = hits(regAddr, MASTER_IRQ_MASK_OFS);
    wire selLoopStatus   = hits(regAddr, LOOP_STATUS_OFS);
    wire selLoopMask     = hits(regAddr, LOOP_IRQ_MASK_OFS);

    wire rdMasterStatus  = regRd & selMasterStatus;
    wire rdLoopStatus    = regRd & selLoopStatus;

    // The local bus is only watched in bridge mode
    wire bridgeMode      = ~localCfgMode;

    // Local ready watchdog, stepped by sampled local clock edges
    local_ready_watchdog uWatchdog (
        .clk           (clk),
        .rst_n         (rst_n),
        .enable        (bridgeMode),
        .accessStart   (localAccessStart),
        .localBusClock (localBusClock),
        .localReady_n  (localReady_n),
        .timeoutPulse  (localTimeoutEvt)
    );

    // Local interrupt counts once per falling edge, so a held level
    // does not refill the flag straight after every read
    wire localIrqEvt = bridgeMode & localIrqPrev_q & ~localIrqIn_n;

    // Master flag sources; bits 0..2 belong to other blocks and stay 0
    wire [REG_WIDTH-1:0] masterSet;
    assign masterSet[2:0]            = 3'h0;
    assign masterSet[SYS_ERR_BIT]    = hostSysErrEvt;
    assign masterSet[PARITY_ERR_BIT] = hostParityErrEvt;
    assign masterSet[LOCAL_TIMEOUT_BIT-1:PARITY_ERR_BIT+1] = '0;
    assign masterSet[LOCAL_TIMEOUT_BIT] = localTimeoutEvt;
    assign masterSet[LOCAL_IRQ_BIT]  = localIrqEvt;

    assign masterBank.setPulse = masterSet;
    assign masterBank.clearReq = {REG_WIDTH{rdMasterStatus}};

    // Timeout is a level, so the flag refills every cycle it stays high
    assign loopBank.setPulse = loopPatternEvt |
                               loopSearchTimeout;
    assign loopBank.clearReq = {PORT_COUNT{rdLoopStatus}};

    sticky_flag_bank #(.WIDTH(REG_WIDTH)) uMasterFlags (
        .clk   (clk),
        .rst_n (rst_n),
        .bank  (masterBank)
    );

    sticky_flag_bank #(.WIDTH(PORT_COUNT)) uLoopFlags (
        .clk   (clk),
        .rst_n (rst_n),
        .bank  (loopBank)
    );

    // Mask writes; unimplemented master mask bits stay zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            masterMask_q <= REG_RESET;
            loopMask_q   <= REG_RESET[PORT_COUNT-1:0];
        end else if (regWr) begin
            if (selMasterMask) begin
                masterMask_q <= regWrData & MASTER_MASK_IMPL;
            end
            if (selLoopMask) begin
                loopMask_q <= regWrData[PORT_COUNT-1:0];
            end
        end
    end

    // Read mux; status writes are ignored, unmapped reads return zero
    always_comb begin
        rdData_d = '0;
        if (regRd) begin
            if (selMasterStatus) begin
                rdData_d = masterBank.flags;
            end else if (selMasterMask) begin
                rdData_d = masterMask_q;
            end else if (selLoopStatus) begin
                rdData_d = loopBank.flags;
            end else if (selLoopMask) begin
                rdData_d = loopMask_q;
            end
        end
    end

    // Masks gate only the outputs; the flags above never see them
    wire [REG_WIDTH-1:0]  masterLive = masterBank.flags &
                                       masterMask_q;
    wire [PORT_COUNT-1:0] loopLive   = loopBank.flags &
                                       loopMask_q;

    wire [REG_WIDTH-1:0]  localOnlyMask = ~(REG_WIDTH'(1) << LOCAL_IRQ_BIT);

    wire anyHostIrq  = (|masterLive) | (|loopLive);
    // Local interrupt flag is left out of the local pin by design
    wire anyLocalIrq = (|(masterLive & localOnlyMask)) |
                       (|loopLive);

    // Registered outputs; host pin stays low while a live flag is set, local pin only in config mode and not for bit 15
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdData_q        <= REG_RESET;
            localIrqPrev_q  <= 1'b1;
            hostIrq_n_q     <= 1'b1;
            localIrqOut_n_q <= 1'b1;
            localIrqOe_q    <= 1'b0;
            cfgSysErr_q     <= 1'b0;
            cfgParityErr_q  <= 1'b0;
        end else begin
            rdData_q        <= rdData_d;
            localIrqPrev_q  <= localIrqIn_n;
            hostIrq_n_q     <= ~anyHostIrq;
            localIrqOut_n_q <= ~(anyLocalIrq & localCfgMode);
            localIrqOe_q    <= localCfgMode;
            cfgSysErr_q     <= masterBank.flags[SYS_ERR_BIT];
            cfgParityErr_q  <= masterBank.flags[PARITY_ERR_BIT];
        end
    end

    assign regRdData        = rdData_q;
    assign hostIrqOut_n     = hostIrq_n_q;
    assign localIrqOut_n    = localIrqOut_n_q;
    assign localIrqOe       = localIrqOe_q;
    assign cfgSysErrFlag    = cfgSysErr_q;
    assign cfgParityErrFlag = cfgParityErr_q;

endmodule

//--- dv/status_interrupt_flags_assertions.sv
// Concurrent checks on the ports of the status and interrupt flag block
`timescale 1ns/1ps
module status_interrupt_flags_checker
    import status_irq_pkg::*;
(
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  rst_n,
    // Register port
    input wire logic [7:0]            regAddr,
    input wire logic [REG_WIDTH-1:0]  regWrData,
    input wire logic                  regWr,
    input wire logic                  regRd,
    input wire logic [REG_WIDTH-1:0]  regRdData,
    // Events, mode and outputs
    input wire logic                  hostSysErrEvt,
    input wire logic                  hostParityErrEvt,
    input wire logic                  cfgSysErrFlag,
    input wire logic                  cfgParityErrFlag,
    input wire logic                  localCfgMode,
    input wire logic                  localIrqOut_n,
    input wire logic                  localIrqOe,
    input wire logic [PORT_COUNT-1:0] loopSearchTimeout,
    input wire logic                  hostIrqOut_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Write that lets the system error through to the interrupt lines
    sequence maskSysOn;
        regWr && regAddr == MASTER_IRQ_MASK_OFS && regWrData[SYS_ERR_BIT];
    endsequence
    // Both mask registers cleared back to back
    sequence masksOff;
        regWr && regAddr == MASTER_IRQ_MASK_OFS && regWrData == 16'h0000
        ##1 regWr && regAddr == LOOP_IRQ_MASK_OFS && regWrData == 16'h0000;
    endsequence

    AST_RD_ONE_CYCLE: assert property (
        !$past(regRd) |-> regRdData == 16'h0000)
        else $error("read data outside its cycle");
    AST_SYS_SET: assert property (hostSysErrEvt |-> ##2 cfgSysErrFlag)
        else $error("system error not recorded");
    AST_PAR_SET: assert property (
        hostParityErrEvt |-> ##2 cfgParityErrFlag)
        else $error("parity error not recorded");
    AST_SYS_CLEAR: assert property (
        regRd && regAddr == MASTER_STATUS_OFS && !hostSysErrEvt
        |-> ##2 !cfgSysErrFlag)
        else $error("system error survived a read");
    AST_OE_MODE: assert property (
        $past(rst_n) && $stable(localCfgMode) |-> localIrqOe == localCfgMode)
        else $error("local pin drive does not follow mode");
    AST_MASK_RSVD: assert property (
        regRd && regAddr == MASTER_IRQ_MASK_OFS
        |=> (regRdData & ~MASTER_MASK_IMPL) == 16'h0000)
        else $error("unimplemented mask bit read back");
    AST_HOST_IRQ_ON: assert property (
        maskSysOn ##1 hostSysErrEvt |-> ##2 !hostIrqOut_n)
        else $error("unmasked flag did not raise host line");
    AST_LOCAL_PIN: assert property (
        maskSysOn ##1 (hostSysErrEvt && localCfgMode) ##1 localCfgMode[*2]
        |-> !localIrqOut_n)
        else $error("config mode local pin not raised");
    AST_LOOP_HOLD: assert property (
        regRd && regAddr == LOOP_STATUS_OFS && loopSearchTimeout[0]
        && $past(loopSearchTimeout[0]) |=> regRdData[0])
        else $error("held timeout flag read as clear");
    AST_IRQ_OFF: assert property (masksOff |=> ##1 hostIrqOut_n)
        else $error("host line low with all masks clear");
endmodule

bind status_interrupt_flags status_interrupt_flags_checker chk (
    .clk, .rst_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .hostSysErrEvt, .hostParityErrEvt, .cfgSysErrFlag, .cfgParityErrFlag,
    .localCfgMode, .localIrqOut_n, .localIrqOe, .loopSearchTimeout,
    .hostIrqOut_n
);

//--- dv/local_bus_peer.sv
// Model of a local bus peripheral: clock, ready and interrupt lines
`timescale 1ns/1ps
module local_bus_peer (
    // Clock and access trigger
    input  wire logic       clk,
    input  wire logic       start,
    // Behaviour knobs, a zero delay never answers
    input  wire logic [3:0] readyDelay,
    input  wire logic       irqReq,
    // Local bus lines
    output logic            local_bus_clock,
    output logic            ready_n,
    output logic            irq_n
);
    logic [1:0] ph = 2'h0;
    logic [3:0] edges = 4'h0;
    logic       run = 1'b0;
    // Clock stands low between accesses, a quarter of clk rate inside
    assign local_bus_clock = run & ph[1];
    // Ready is pulled high except on the chosen local clock period
    assign ready_n = !(run && readyDelay != 4'h0 && edges == readyDelay);
    // Open-drain interrupt, pulled up unless requested
    assign irq_n = !irqReq;
    // Access runs past the nine-period limit, then the clock stops
    always @(posedge clk) begin
        if (start) begin
            run <= 1'b1;
            ph <= 2'h0;
            edges <= 4'h0;
        end else if (run) begin
            ph <= ph + 2'h1;
            if (ph == 2'h1) edges <= edges + 4'h1;
            if (edges == 4'hC) run <= 1'b0;
        end
    end
endmodule

//--- dv/tb.sv
// Self-checking bench for the status and interrupt flag block
`timescale 1ns/1ps
module tb
    import status_irq_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
    logic        hostSysErrEvt = 1'b0, hostParityErrEvt = 1'b0;
    logic        localCfgMode = 1'b0, localAccessStart = 1'b0, irqReq = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [15:0] regWrData = 16'h0000, loopPatternEvt = 16'h0000;
    logic [15:0] loopSearchTimeout = 16'h0000, regRdData;
    logic [3:0]  rdyDelay = 4'h0;
    logic        localBusClock, localReady_n, peerIrq_n, localIrqOut_n;
    logic        localIrqOe, hostIrqOut_n, cfgSysErrFlag, cfgParityErrFlag;
    int          errorCnt = 0, cmpCount = 0, cycles = 0, r1, r2;
    int          mS = 0, mM = 0, lS = 0, lM = 0;
    logic [7:0]  ofsQ[$] = '{8'h20, 8'h24, 8'h30, 8'h34, 8'h28};
    // Wired-AND interrupt line, released by both ends means high
    wire         irqLine_n = (localIrqOe ? localIrqOut_n : 1'b1) & peerIrq_n;

    status_interrupt_flags status_interrupt_flags_inst (
        .clk, .rst_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
        .hostSysErrEvt, .hostParityErrEvt, .cfgSysErrFlag, .cfgParityErrFlag,
        .localCfgMode, .localAccessStart, .localBusClock, .localReady_n,
        .localIrqIn_n(irqLine_n), .localIrqOut_n, .localIrqOe,
        .loopSearchTimeout, .loopPatternEvt, .hostIrqOut_n
    );
    local_bus_peer local_bus_peer_inst (
        .clk, .start(localAccessStart), .readyDelay(rdyDelay), .irqReq,
        .local_bus_clock(localBusClock), .ready_n(localReady_n), .irq_n(peerIrq_n)
    );

    always #2.5 clk = ~clk;
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            errorCnt++;
            summarize();
        end
    end

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmpCount, errorCnt);
        if (errorCnt == 0 && cmpCount > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        cmpCount++;
        if (got !== exp) begin
            errorCnt++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmpPin(input logic got, input logic exp);
        cmp({15'h0000, got}, {15'h0000, exp});
    endtask
    // Write leaves the strobe up so writes may run back to back
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        if (a == MASTER_IRQ_MASK_OFS) mM = d & MASTER_MASK_IMPL;
        if (a == LOOP_IRQ_MASK_OFS) lM = d;
    endtask
    // Read, optionally with a system error in the same cycle
    task automatic rd(input logic [7:0] a, input logic sev);
        int exp;
        regWr <= 1'b0;
        regRd <= 1'b1;
        regAddr <= a;
        hostSysErrEvt <= sev;
        @(posedge clk);
        regRd <= 1'b0;
        hostSysErrEvt <= 1'b0;
        case (a)
            MASTER_STATUS_OFS:   exp = mS;
            MASTER_IRQ_MASK_OFS: exp = mM;
            LOOP_STATUS_OFS:     exp = lS;
            LOOP_IRQ_MASK_OFS:   exp = lM;
            default:             exp = 0;
        endcase
        if (a == MASTER_STATUS_OFS) mS = sev ? 16'h0008 : 16'h0000;
        if (a == LOOP_STATUS_OFS) lS = loopSearchTimeout;
        @(negedge clk);
        cmp(regRdData, exp[15:0]);
        @(posedge clk);
    endtask
    task automatic ev(input logic s, input logic p, input logic [15:0] l);
        regWr <= 1'b0;
        hostSysErrEvt <= s;
        hostParityErrEvt <= p;
        loopPatternEvt <= l;
        @(posedge clk);
        hostSysErrEvt <= 1'b0;
        hostParityErrEvt <= 1'b0;
        loopPatternEvt <= 16'h0000;
        mS |= {p, s, 3'h0};
        lS |= l;
        @(posedge clk);
    endtask
    task automatic step(input int n);
        regWr <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
    // Host line sees every live flag; local pin all but bit 15
    task automatic irqChk();
        int loc;
        loc = ((mS & mM & 16'h7FFF) | (lS & lM)) != 0 && localCfgMode;
        repeat (2) @(posedge clk);
        @(negedge clk);
        cmpPin(hostIrqOut_n, ((mS & mM) | (lS & lM)) == 0);
        cmpPin(irqLine_n, !(loc[0] || irqReq));
        @(posedge clk);
    endtask

    initial begin
        void'($urandom(32));
        r1 = $urandom;
        r2 = $urandom;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (ofsQ[i]) rd(ofsQ[i], 1'b0);
        // Status ignores writes; masks keep only implemented bits
        wr(MASTER_STATUS_OFS, 16'hFFFF);
        wr(MASTER_IRQ_MASK_OFS, r1[15:0]);
        wr(LOOP_IRQ_MASK_OFS, r2[15:0]);
        rd(MASTER_STATUS_OFS, 1'b0);
        rd(MASTER_IRQ_MASK_OFS, 1'b0);
        rd(LOOP_IRQ_MASK_OFS, 1'b0);
        // Masked events still record, and one read clears them
        wr(MASTER_IRQ_MASK_OFS, 16'h0000);
        wr(LOOP_IRQ_MASK_OFS, 16'h0000);
        ev(1'b1, 1'b1, 16'h0000);
        irqChk();
        @(negedge clk);
        cmpPin(cfgSysErrFlag, mS[SYS_ERR_BIT]);
        cmpPin(cfgParityErrFlag, mS[PARITY_ERR_BIT]);
        @(posedge clk);
        rd(MASTER_STATUS_OFS, 1'b0);
        rd(MASTER_STATUS_OFS, 1'b0);
        rd(MASTER_STATUS_OFS, 1'b1);
        rd(MASTER_STATUS_OFS, 1'b0);
        // Unmasked flag in bridge mode, then in config mode
        for (int m = 0; m < 2; m++) begin
            localCfgMode <= m[0];
            wr(MASTER_IRQ_MASK_OFS, 16'h0008);
            ev(1'b1, 1'b0, 16'h0000);
            irqChk();
            rd(MASTER_STATUS_OFS, 1'b0);
            irqChk();
        end
        // Port flags; a held timeout keeps its flag up across reads
        localCfgMode <= 1'b0;
        wr(LOOP_IRQ_MASK_OFS, 16'hFFFF);
        ev(1'b0, 1'b0, r2[31:16]);
        irqChk();
        rd(LOOP_STATUS_OFS, 1'b0);
        rd(LOOP_STATUS_OFS, 1'b0);
        loopSearchTimeout <= 16'h0001;
        step(2);
        lS = 1;
        repeat (2) rd(LOOP_STATUS_OFS, 1'b0);
        loopSearchTimeout <= 16'h0000;
        step(2);
        repeat (2) rd(LOOP_STATUS_OFS, 1'b0);
        // Access with no ready, then one answered on the third period
        for (int d = 0; d < 2; d++) begin
            rdyDelay <= d[0] ? 4'h3 : 4'h0;
            localAccessStart <= 1'b1;
            @(posedge clk);
            localAccessStart <= 1'b0;
            step(60);
            mS |= (d == 0) ? 16'h4000 : 16'h0000;
            rd(MASTER_STATUS_OFS, 1'b0);
        end
        // Local interrupt input reaches the host line only
        wr(MASTER_IRQ_MASK_OFS, 16'h8000);
        irqReq <= 1'b1;
        step(4);
        mS = 16'h8000;
        irqChk();
        repeat (2) rd(MASTER_STATUS_OFS, 1'b0);
        irqReq <= 1'b0;
        step(2);
        summarize();
    end
endmodule
